// >>> bench/fec_flash_model.sv
/*
 Flash array model for the erase controller bench: answers each erase
 request with a one-cycle done pulse after a delay set by the bench.
 Assumes erase requests are levels that drop the cycle after the pulse.
*/
`timescale 1ns/1ps
module fec_flash_model
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Erase requests and answer
   input wire logic page_erase_i,
   input wire logic mass_erase_i,
   input wire logic [7:0] delay_i,
   output logic done_o
);
   logic [7:0] cnt_r;

   // Count the erase time, then pulse done once; a long delay keeps the stall visible
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cnt_r <= 8'h00;
         done_o <= 1'b0;
      end
      else if (!(page_erase_i || mass_erase_i) || done_o)
      begin
         cnt_r <= 8'h00;
         done_o <= 1'b0;
      end
      else if (cnt_r == delay_i)
         done_o <= 1'b1;
      else
         cnt_r <= cnt_r + 8'h01;
   end
endmodule : fec_flash_model

// >>> bench/tb_flash_erase_controller.sv
/*
 Self-checking bench for the flash erase controller: APB tasks, erase
 sequences, info page mapping, trim register and bypass pins.
 Assumes a zero-wait APB slave and the array model in fec_flash_model.
 The bench raises the program strobe only in the bypass pin test, with no address 
*/
`timescale 1ns/1ps
module tb_flash_erase_controller
   import fec_pkg::*;
;
   logic sys_clk, resetn, psel, penable, pwrite, pdebug, flash_done, gpio_erase, gpio_prog;
   logic [15:0] paddr, prog_addr, er_addr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, pg_er, ms_er, prog, stall, info_rd, err;
   logic [7:0] info_addr, dly;
   logic pg_q = 1'b0;
   logic ms_q = 1'b0;
   int miscompares, checks_done, n_pg, n_ms;

   fec_flash_erase_controller uut (.sys_clk_i(sys_clk), .resetn_i(resetn), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pdebug_i(pdebug), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .flash_done_i(flash_done), .flash_page_erase_o(pg_er), .flash_mass_erase_o(ms_er),
      .flash_prog_o(prog), .flash_erase_addr_o(er_addr), .prog_addr_i(prog_addr),
      .cpu_stall_o(stall), .info_rd_o(info_rd), .info_addr_o(info_addr),
      .gpio_erase_i(gpio_erase), .gpio_prog_i(gpio_prog));

   fec_flash_model array (.sys_clk_i(sys_clk), .resetn_i(resetn), .page_erase_i(pg_er),
      .mass_erase_i(ms_er), .delay_i(dly), .done_o(flash_done));

   // ----------------------------------------
   // Clock, erase start counters, watchdog
   // ----------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Count rising edges of the erase requests so refused commands show up;
   // sampled on the falling edge so a check right after the request edge sees it
   always @(negedge sys_clk)
   begin
      pg_q <= pg_er;
      ms_q <= ms_er;
      if (pg_er && !pg_q)
         n_pg <= n_pg + 1;
      if (ms_er && !ms_q)
         n_ms <= n_ms + 1;
   end

   // Whole run needs well under 2000 cycles
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      end_of_test;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task end_of_test;
      if (miscompares == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk

   // One APB transfer; an idle edge follows so back-to-back calls never collide
   task apb(input logic wr, input logic [11:0] idx, input logic [7:0] d, input logic dbg);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, d};
      pdebug <= dbg;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   // Poll status until the busy bit clears, as a debugger would; only the watchdog ends a hang
   task wait_idle(input logic dbg);
      do
         apb(1'b0, FEC_IDX_STAT, 8'h00, dbg);
      while (rd[FEC_STAT_BUSY] !== 1'b0);
   endtask : wait_idle

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {resetn, psel, penable, pwrite, pdebug, gpio_erase, gpio_prog} = 7'h00;
      paddr = 16'h0000;
      pwdata = 32'h00000000;
      prog_addr = 16'h0000;
      dly = 8'h00;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      // Trim register: reset value, top legal value, out of range refused
      apb(1'b0, FEC_IDX_TRIM, 8'h00, 1'b0);
      chk(rd, 32'(FEC_TRIM_RST), "trim reset");
      apb(1'b1, FEC_IDX_TRIM, FEC_TRIM_MAX, 1'b0);
      apb(1'b1, FEC_IDX_TRIM, 8'h20, 1'b0);
      apb(1'b0, FEC_IDX_TRIM, 8'h00, 1'b0);
      chk(rd, 32'(FEC_TRIM_MAX), "trim range");
      // Reset in mid-run brings the trim address back to zero
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      apb(1'b0, FEC_IDX_TRIM, 8'h00, 1'b0);
      chk(rd, 32'(FEC_TRIM_RST), "trim after reset");
      apb(1'b0, 12'h100, 8'h00, 1'b0);
      chk(32'(err), 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      // Locked controller ignores the page command
      apb(1'b1, FEC_IDX_PAGE, 8'h03, 1'b0);
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_PAGE, 1'b0);
      chk(32'(n_pg), 32'h0, "locked page erase");
      chk(32'(er_addr), 32'(3 * FEC_PAGE_BYTES), "erase address");
      // Page erase with a prompt array
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_UNLOCK, 1'b0);
      apb(1'b0, FEC_IDX_STAT, 8'h00, 1'b0);
      chk(rd, 32'((1 << FEC_STAT_UNLK) | (1 << FEC_STAT_PSET)), "unlocked status");
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_PAGE, 1'b0);
      chk(32'({pg_er, stall}), 32'h3, "page erase running");
      wait_idle(1'b0);
      chk(32'(n_pg), 32'h1, "page erase start");
      chk(rd, 32'h0, "relock after page");
      chk(32'(stall), 32'h0, "stall released");
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_PAGE, 1'b0);
      chk(32'(n_pg), 32'h1, "relocked page erase");
      // Page in a protected sector is not erased
      apb(1'b1, FEC_IDX_PROT, 8'h20, 1'b0);
      apb(1'b1, FEC_IDX_PAGE, 8'h05, 1'b0);
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_UNLOCK, 1'b0);
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_PAGE, 1'b0);
      chk(32'(n_pg), 32'h1, "protected page");
      // Mass erase from the CPU is refused, from the debug port runs slowly
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_MASS_EN, 1'b0);
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_MASS, 1'b0);
      chk(32'(n_ms), 32'h0, "cpu mass erase");
      dly <= 8'd40;
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_UNLOCK, 1'b1);
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_MASS_EN, 1'b1);
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_MASS, 1'b0);
      chk(32'(n_ms), 32'h0, "enabled cpu mass erase");
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_MASS, 1'b1);
      chk(32'(stall), 32'h1, "mass stall");
      chk(32'(ms_er), 32'h1, "mass request");
      wait_idle(1'b1);
      chk(32'(n_ms), 32'h1, "mass erase count");
      chk(rd, 32'h0, "relock after mass");
      chk(32'(stall), 32'h0, "mass stall end");
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_MASS_EN, 1'b1);
      apb(1'b1, FEC_IDX_CTRL, FEC_CMD_MASS, 1'b1);
      chk(32'(n_ms), 32'h1, "locked mass erase");
      // Info page mapping survives the mass erase
      apb(1'b1, FEC_IDX_PAGE, FEC_INFO_SEL, 1'b0);
      prog_addr <= 16'hfe60;
      @(posedge sys_clk);
      chk(32'(info_rd), 32'h1, "info map");
      chk(32'(info_addr), 32'h60, "info address");
      prog_addr <= 16'h1e60;
      @(posedge sys_clk);
      chk(32'(info_rd), 32'h0, "main map");
      // Bypass hands the page erase and program strobes to the pins; mass erase is held low
      apb(1'b1, FEC_IDX_BYP, 8'h01, 1'b0);
      gpio_erase <= 1'b1;
      gpio_prog <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk(32'({pg_er, prog}), 32'h3, "bypass high");
      gpio_erase <= 1'b0;
      gpio_prog <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk(32'({pg_er, prog}), 32'h0, "bypass low");
      end_of_test;
   end
endmodule : tb_flash_erase_controller

// >>> rtl/fec_flash_erase_controller.sv
/*
 Flash erase controller: APB register slave, page and mass erase
 sequencer, CPU stall, bypass of the page erase and program strobes to GPIO pins and
 information page read mapping.
 Assumes the flash array answers each erase request with a one-cycle
 done pulse on sys_clk_i, and the debug port flags its own accesses.
*/
`timescale 1ns/1ps
module fec_flash_erase_controller
   import fec_pkg::*;
#(
   parameter int PAGE_W = 7,
   parameter int SECT_N = 8
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pdebug_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Flash array
   input wire logic flash_done_i,
   output logic flash_page_erase_o,
   output logic flash_mass_erase_o,
   output logic flash_prog_o,
   output logic [15:0] flash_erase_addr_o,
   // CPU program memory reads
   input wire logic [15:0] prog_addr_i,
   output logic cpu_stall_o,
   output logic info_rd_o,
   output logic [7:0] info_addr_o,
   // Bypass GPIO pins
   input wire logic gpio_erase_i,
   input wire logic gpio_prog_i
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   fec_state_t state_r;
   logic unlocked_r;
   logic mass_en_r;
   logic page_set_r;
   logic bypass_r;
   logic [7:0] page_r;
   logic [7:0] prot_r;
   logic [7:0] trim_r;
   logic [31:0] prdata_r;
   logic [2:0] sync_r [2];
   logic [1:0] gpio_r;
   logic acc;
   logic wr;
   logic [11:0] idx;
   logic mapped;
   logic [7:0] wbyte;
   logic page_ok;
   logic cmd_page;
   logic cmd_mass;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   // Slave answers in the first access cycle, so pready is constant high
   assign acc = psel_i & penable_i;
   assign wr = acc & pwrite_i;
   assign idx = paddr_i[FEC_IDX_LSB +: 12];
   assign wbyte = pwdata_i[7:0];
   assign mapped = (idx == FEC_IDX_TRIM) | (idx == FEC_IDX_CTRL) |
                   (idx == FEC_IDX_STAT) | (idx == FEC_IDX_PAGE) |
                   (idx == FEC_IDX_PROT) | (idx == FEC_IDX_BYP);
   assign pready_o = 1'b1;
   assign pslverr_o = acc & ~mapped;
   assign prdata_o = prdata_r;

   // Sector check: a protect bit per sector guards its pages
   assign page_ok = ~prot_r[3'((page_r[PAGE_W-1:0] / FEC_SECT_PAGES) % SECT_N)];
   assign cmd_page = wr & (idx == FEC_IDX_CTRL) & (wbyte == FEC_CMD_PAGE) &
                     unlocked_r & page_set_r & page_ok & (state_r == FEC_IDLE);
   assign cmd_mass = wr & (idx == FEC_IDX_CTRL) & (wbyte == FEC_CMD_MASS) &
                     unlocked_r & mass_en_r & pdebug_i & (state_r == FEC_IDLE);

   // ----------------------------------------
   // Read data, registered so it is stable in the next access
   // ----------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         prdata_r <= 32'h0000_0000;
      else if (psel_i & ~penable_i & ~pwrite_i)
      begin
         case (idx)
            FEC_IDX_TRIM: prdata_r <= {24'h00_0000, trim_r};
            FEC_IDX_STAT: prdata_r <= {28'h000_0000, page_set_r, mass_en_r, unlocked_r,
                                       state_r != FEC_IDLE};
            FEC_IDX_PAGE: prdata_r <= {24'h00_0000, page_r};
            FEC_IDX_PROT: prdata_r <= {24'h00_0000, prot_r};
            FEC_IDX_BYP: prdata_r <= {31'h0000_0000, bypass_r};
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // Software configuration registers
   // ----------------------------------------
   // Out-of-range trim addresses are dropped rather than wrapped
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         trim_r <= FEC_TRIM_RST;
      else if (wr & (idx == FEC_IDX_TRIM) & (wbyte <= FEC_TRIM_MAX))
         trim_r <= wbyte;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         prot_r <= FEC_PROT_RST;
         bypass_r <= 1'b0;
      end
      else
      begin
         if (wr & (idx == FEC_IDX_PROT))
            prot_r <= wbyte;
         if (wr & (idx == FEC_IDX_BYP) & (state_r == FEC_IDLE))
            bypass_r <= wbyte[0];
      end
   end

   // Page select; writing it marks the active page as set
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         page_r <= FEC_PAGE_RST;
         page_set_r <= 1'b0;
      end
      else if (state_r != FEC_IDLE && flash_done_i)
         page_set_r <= 1'b0;
      else if (wr & (idx == FEC_IDX_PAGE) & (state_r == FEC_IDLE))
      begin
         page_r <= wbyte;
         page_set_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Lock state
   // ----------------------------------------
   // Completion takes priority over any write in the same cycle
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         unlocked_r <= 1'b0;
         mass_en_r <= 1'b0;
      end
      else if (state_r != FEC_IDLE && flash_done_i)
      begin
         unlocked_r <= 1'b0;
         mass_en_r <= 1'b0;
      end
      else if (wr & (idx == FEC_IDX_CTRL) & (state_r == FEC_IDLE))
      begin
         if (wbyte == FEC_CMD_UNLOCK)
            unlocked_r <= 1'b1;
         else if (wbyte == FEC_CMD_MASS_EN && unlocked_r && pdebug_i)
            mass_en_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Erase sequencer
   // ----------------------------------------
   // A locked controller never leaves idle on a command code
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         state_r <= FEC_IDLE;
      else
      begin
         case (state_r)
            FEC_IDLE:
            begin
               if (bypass_r)
                  state_r <= FEC_IDLE;
               else if (cmd_page)
                  state_r <= FEC_PAGE_ER;
               else if (cmd_mass)
                  state_r <= FEC_MASS_ER;
            end
            FEC_PAGE_ER, FEC_MASS_ER:
               if (flash_done_i)
                  state_r <= FEC_IDLE;
            default: state_r <= FEC_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Bypass pin synchronisers
   // ----------------------------------------
   // Three stages; the value moves only when stages two and three agree
   for (genvar g = 0; g < 2; g++)
   begin : g_sync
      always_ff @(posedge sys_clk_i or negedge resetn_i)
      begin
         if (!resetn_i)
         begin
            sync_r[g] <= 3'h0;
            gpio_r[g] <= 1'b0;
         end
         else
         begin
            sync_r[g] <= {sync_r[g][1:0], (g == 0) ? gpio_erase_i : gpio_prog_i};
            if (sync_r[g][1] == sync_r[g][2])
               gpio_r[g] <= sync_r[g][2];
         end
      end
   end

   // ----------------------------------------
   // Array controls
   // ----------------------------------------
   // Mass erase drives the main-array strobe only; info page has none
   assign flash_page_erase_o = bypass_r ? gpio_r[0] : (state_r == FEC_PAGE_ER);
   assign flash_prog_o = bypass_r & gpio_r[1];
   assign flash_mass_erase_o = ~bypass_r & (state_r == FEC_MASS_ER);
   assign flash_erase_addr_o = 16'(page_r[PAGE_W-1:0]) << FEC_PAGE_SHIFT;
   assign cpu_stall_o = (state_r != FEC_IDLE);

   // Info page appears at 0xfe00-0xfeff of program space when selected
   assign info_rd_o = (page_r == FEC_INFO_SEL) & (prog_addr_i[15:8] == FEC_INFO_HI) &
                      (state_r == FEC_IDLE);
   assign info_addr_o = prog_addr_i[7:0];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_page_cmd;
      cmd_page & ~bypass_r;
   endsequence
   sequence s_erase_end;
      (state_r != FEC_IDLE) & flash_done_i;
   endsequence

   property p_page_start;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      s_page_cmd |=> flash_page_erase_o & cpu_stall_o;
   endproperty
   a_page_start: assert property (p_page_start) else $error("page erase not started");

   property p_relock;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      s_erase_end |=> !unlocked_r && state_r == FEC_IDLE && !cpu_stall_o;
   endproperty
   a_relock: assert property (p_relock) else $error("no relock after erase");

   property p_locked_ignore;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (state_r == FEC_IDLE) && !unlocked_r |=> state_r == FEC_IDLE;
   endproperty
   a_locked_ignore: assert property (p_locked_ignore) else $error("locked erase ran");

   property p_prot;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      $rose(state_r == FEC_PAGE_ER) |-> $past(page_ok);
   endproperty
   a_prot: assert property (p_prot) else $error("protected page erased");

   property p_mass_dbg;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      $rose(state_r == FEC_MASS_ER) |-> $past(pdebug_i) && $past(mass_en_r);
   endproperty
   a_mass_dbg: assert property (p_mass_dbg) else $error("mass erase without debug");

   property p_stall;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (state_r != FEC_IDLE) & !flash_done_i |=> cpu_stall_o;
   endproperty
   a_stall: assert property (p_stall) else $error("cpu not stalled");

   property p_info_map;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (page_r == FEC_INFO_SEL) && prog_addr_i == 16'hfe60 && state_r == FEC_IDLE
         |-> info_rd_o && info_addr_o == 8'h60;
   endproperty
   a_info_map: assert property (p_info_map) else $error("info page not mapped");

   property p_trim;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      trim_r <= FEC_TRIM_MAX;
   endproperty
   a_trim: assert property (p_trim) else $error("trim address out of range");

   property p_bypass;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      bypass_r |-> !flash_mass_erase_o && flash_page_erase_o == gpio_r[0];
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not routed");

   property p_mass_keep_info;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      flash_mass_erase_o |-> !info_rd_o && !flash_page_erase_o;
   endproperty
   a_mass_keep_info: assert property (p_mass_keep_info) else $error("info touched");
endmodule : fec_flash_erase_controller

// >>> rtl/fec_pkg.sv
/*
 Constants for the flash erase controller: register indices, command
 codes, field layouts and reset values. Assumes a 32-bit APB bus.
*/
package fec_pkg;
   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [11:0] FEC_IDX_TRIM = 12'hff6;
   localparam logic [11:0] FEC_IDX_CTRL = 12'hff8;
   localparam logic [11:0] FEC_IDX_STAT = 12'hff9;
   localparam logic [11:0] FEC_IDX_PAGE = 12'hffa;
   localparam logic [11:0] FEC_IDX_PROT = 12'hffb;
   localparam logic [11:0] FEC_IDX_BYP = 12'hffc;
   localparam int FEC_IDX_LSB = 2;
   // ----------------------------------------
   // Command codes written to the control register
   // ----------------------------------------
   localparam logic [7:0] FEC_CMD_UNLOCK = 8'h73;
   localparam logic [7:0] FEC_CMD_MASS_EN = 8'h8c;
   localparam logic [7:0] FEC_CMD_PAGE = 8'h95;
   localparam logic [7:0] FEC_CMD_MASS = 8'h63;
   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam logic [7:0] FEC_INFO_SEL = 8'h80;
   localparam logic [7:0] FEC_TRIM_MAX = 8'h1f;
   localparam logic [7:0] FEC_TRIM_RST = 8'h00;
   localparam logic [7:0] FEC_PAGE_RST = 8'h00;
   localparam logic [7:0] FEC_PROT_RST = 8'h00;
   localparam logic [7:0] FEC_INFO_HI = 8'hfe;
   localparam int FEC_STAT_BUSY = 0;
   localparam int FEC_STAT_UNLK = 1;
   localparam int FEC_STAT_MEN = 2;
   localparam int FEC_STAT_PSET = 3;
   localparam int FEC_PAGE_BYTES = 512;
   localparam int FEC_PAGE_SHIFT = 9;
   localparam int FEC_SECT_PAGES = 1;
   typedef enum logic [1:0] {FEC_IDLE, FEC_PAGE_ER, FEC_MASS_ER} fec_state_t;
endpackage : fec_pkg
